/* File: ldr_bank.sv */
// Function
// - An 8-bit PWM level picks one of 256 duty-cycle steps for the LEDs.
// - Level zero gives the minimum output with the LEDs held off.
// - Levels 1 to 255 give duty n/255 in absolute mode, linear, about 0.39% per step.
// - A write to the PWM level register lands only in bus dimming mode.
// - Reading the PWM level register returns the programmed value always.
// - Level all ones drives the enabled outputs at full duty in absolute bus mode.
// - The PWM level register resets to all ones.
// - A separate 8-bit DC level register sets the channel current step.
// - Config decodes short threshold (0x off, 10 low, 11 high) and freq bit.
// - Channel bits enable on write and read back healthy-and-enabled.
// - Source select 1 uses external PWM; else interp picks absolute/scaled.
module ldr_bank #(
  parameter logic [15:0] PWM_DIV = ldr_pkg::PWM_DIV_DEFAULT
) (
  // Clock, reset, enable
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  // Byte register access
  input wire ldr_pkg::ldr_req_t BUS_REQ,
  output ldr_pkg::ldr_rsp_t BUS_RSP,
  // Dimming mode controls
  input wire logic DIM_SRC_SEL,
  input wire logic DIM_INTERP_SEL,
  // Pins from outside
  input wire logic EXT_PWM_INPUT,
  input wire logic [5:0] CH_FAULT,
  // Outputs to the LED stage
  output logic [5:0] LED_PWM,
  output logic [7:0] DC_LEVEL,
  output ldr_pkg::ldr_analog_t ANALOG_CFG
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam ldr_pkg::ldr_state_t RST_STATE = '{
    pwm_level: ldr_pkg::RST_PWM_LEVEL,
    dc_level: ldr_pkg::RST_DC_LEVEL,
    cfg: ldr_pkg::RST_CONFIG,
    ch_en: ldr_pkg::RST_CHANNEL,
    eff_level: ldr_pkg::RST_PWM_LEVEL,
    analog: '{short_en: 1'b1, short_high: 1'b1, freq_high: 1'b1},
    default: '0
  };

  ldr_pkg::ldr_state_t s_q;
  ldr_pkg::ldr_state_t s_d;
  logic [15:0] prod;
  logic [ldr_pkg::MEAS_BITS:0] hi_next;
  logic [ldr_pkg::MEAS_BITS:0] duty_raw;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    prod = 16'h0000;
    hi_next = '0;
    duty_raw = '0;

    // Two-flop synchronisers for pins
    s_d.ext_s1 = EXT_PWM_INPUT;
    s_d.ext_s2 = s_q.ext_s1;
    s_d.flt_s1 = CH_FAULT;
    s_d.flt_s2 = s_q.flt_s1;

    // Writes; unmapped offsets are ignored
    if (BUS_REQ.wr) begin
      unique case (BUS_REQ.addr)
        ldr_pkg::ADDR_PWM_LEVEL: begin
          // Both bus modes accept, external mode drops it
          if (!DIM_SRC_SEL) begin
            s_d.pwm_level = BUS_REQ.wdata;
          end
        end
        ldr_pkg::ADDR_DC_LEVEL: begin
          s_d.dc_level = BUS_REQ.wdata;
        end
        ldr_pkg::ADDR_CONFIG: begin
          s_d.cfg = BUS_REQ.wdata[ldr_pkg::CFG_WIDTH-1:0];
        end
        ldr_pkg::ADDR_CHANNEL: begin
          s_d.ch_en = BUS_REQ.wdata[ldr_pkg::NUM_CH-1:0];
        end
        default: begin
        end
      endcase
    end

    // Reads answer one cycle later; reserved bits and holes read zero
    s_d.rsp.valid = BUS_REQ.rd;
    if (BUS_REQ.rd) begin
      unique case (BUS_REQ.addr)
        ldr_pkg::ADDR_PWM_LEVEL: begin
          s_d.rsp.data = s_q.pwm_level;
        end
        ldr_pkg::ADDR_DC_LEVEL: begin
          s_d.rsp.data = s_q.dc_level;
        end
        ldr_pkg::ADDR_CONFIG: begin
          s_d.rsp.data = {5'h00, s_q.cfg};
        end
        ldr_pkg::ADDR_CHANNEL: begin
          s_d.rsp.data = {2'h0, s_q.ch_en & ~s_q.flt_s2};
        end
        default: begin
          s_d.rsp.data = 8'h00;
        end
      endcase
    end

    // Analog decode of the config field
    s_d.analog.short_en = s_q.cfg[ldr_pkg::CFG_SHORT_HI];
    s_d.analog.short_high = s_q.cfg[ldr_pkg::CFG_SHORT_HI] &
                            s_q.cfg[ldr_pkg::CFG_SHORT_LO];
    s_d.analog.freq_high = s_q.cfg[ldr_pkg::CFG_FREQ_BIT];

    // External duty measured over a fixed window; slow inputs alias
    hi_next = s_q.hi_cnt + {{ldr_pkg::MEAS_BITS{1'b0}}, s_q.ext_s2};
    s_d.meas_cnt = s_q.meas_cnt + 1'b1;
    s_d.hi_cnt = hi_next;
    if (&s_q.meas_cnt) begin
      duty_raw = hi_next >> ldr_pkg::MEAS_SHIFT;
      if (duty_raw[ldr_pkg::MEAS_BITS:8] != '0) begin
        s_d.ext_duty = ldr_pkg::LEVEL_FULL;
      end else begin
        s_d.ext_duty = duty_raw[7:0];
      end
      s_d.hi_cnt = '0;
    end

    // Effective level per dimming mode; rounding keeps 255*255 at 255
    prod = (s_q.pwm_level * s_q.ext_duty) + ldr_pkg::DUTY_ROUND;
    if (DIM_SRC_SEL) begin
      s_d.eff_level = s_q.ext_duty;
    end else if (DIM_INTERP_SEL) begin
      s_d.eff_level = s_q.pwm_level;
    end else begin
      s_d.eff_level = prod[15:8];
    end

    // Dimming clock prescaler
    s_d.tick = 1'b0;
    if (s_q.div_cnt >= PWM_DIV - 16'h0001) begin
      s_d.div_cnt = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.div_cnt = s_q.div_cnt + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      s_q <= RST_STATE;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Channel modulators
  // ----------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < ldr_pkg::NUM_CH; ch++) begin : g_ch
      ldr_pwm_gen u_gen (
        .clk(CLK),
        .reset(RESET),
        .ce(CE),
        .tick(s_q.tick),
        .level(s_q.eff_level),
        .enable(s_q.ch_en[ch]),
        .pwm_out(LED_PWM[ch])
      );
    end
  endgenerate

  assign BUS_RSP = s_q.rsp;
  assign DC_LEVEL = s_q.dc_level;
  assign ANALOG_CFG = s_q.analog;

endmodule : ldr_bank

/* File: ldr_pkg.sv */
package ldr_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PWM_LEVEL = 8'h00;
  localparam logic [7:0] ADDR_DC_LEVEL = 8'h07;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_CHANNEL = 8'h09;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PWM_LEVEL = 8'hff;
  localparam logic [7:0] RST_DC_LEVEL = 8'hff;
  localparam logic [2:0] RST_CONFIG = 3'h7;
  localparam logic [5:0] RST_CHANNEL = 6'h3f;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_SHORT_LO = 0;
  localparam int CFG_SHORT_HI = 1;
  localparam int CFG_FREQ_BIT = 2;
  localparam int CFG_WIDTH = 3;
  localparam int NUM_CH = 6;

  // ----------------------------------------------------------------
  // Timing and arithmetic
  // ----------------------------------------------------------------
  // Counter runs 0..254, so level 255 is always on
  localparam logic [7:0] PWM_LAST = 8'hfe;
  localparam logic [7:0] LEVEL_FULL = 8'hff;
  localparam int DIV_BITS = 16;
  localparam logic [15:0] PWM_DIV_DEFAULT = 16'h0001;
  // Duty window of 2**(MEAS_SHIFT+8) clocks
  localparam int MEAS_SHIFT = 8;
  localparam int MEAS_BITS = MEAS_SHIFT + 8;
  localparam logic [15:0] DUTY_ROUND = 16'h00ff;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ldr_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } ldr_rsp_t;

  typedef struct packed {
    logic short_en;
    logic short_high;
    logic freq_high;
  } ldr_analog_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic out;
  } ldr_gen_t;

  typedef struct packed {
    logic [7:0] pwm_level;
    logic [7:0] dc_level;
    logic [CFG_WIDTH-1:0] cfg;
    logic [NUM_CH-1:0] ch_en;
    ldr_rsp_t rsp;
    ldr_analog_t analog;
    logic ext_s1;
    logic ext_s2;
    logic [NUM_CH-1:0] flt_s1;
    logic [NUM_CH-1:0] flt_s2;
    logic [MEAS_BITS-1:0] meas_cnt;
    logic [MEAS_BITS:0] hi_cnt;
    logic [7:0] ext_duty;
    logic [7:0] eff_level;
    logic [DIV_BITS-1:0] div_cnt;
    logic tick;
  } ldr_state_t;

endpackage : ldr_pkg

/* File: ldr_pwm_gen.sv */
module ldr_pwm_gen (
  // Clock and control
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic tick,
  // Duty setting
  input wire logic [7:0] level,
  input wire logic enable,
  // Output
  output logic pwm_out
);

  ldr_pkg::ldr_gen_t s_q;
  ldr_pkg::ldr_gen_t s_d;

  always_comb begin
    s_d = s_q;
    if (tick) begin
      if (s_q.cnt == ldr_pkg::PWM_LAST) begin
        s_d.cnt = 8'h00;
      end else begin
        s_d.cnt = s_q.cnt + 8'h01;
      end
      // Level 0 never high, 255 always high, n gives n/255
      s_d.out = enable && (s_q.cnt < level);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign pwm_out = s_q.out;

endmodule : ldr_pwm_gen

/* File: ldr_bank_props.sv */
module ldr_bank_props (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  // Register port
  input wire ldr_pkg::ldr_req_t BUS_REQ,
  input wire ldr_pkg::ldr_rsp_t BUS_RSP,
  // Outputs
  input wire logic [5:0] LED_PWM,
  input wire logic [7:0] DC_LEVEL,
  input wire ldr_pkg::ldr_analog_t ANALOG_CFG
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd_go;
  logic wr_go;
  logic mapped;
  logic [2:0] cfg_exp;
  assign rd_go = CE && BUS_REQ.rd;
  assign wr_go = CE && BUS_REQ.wr;
  assign mapped = BUS_REQ.addr inside {8'h00, 8'h07, 8'h08, 8'h09};
  assign cfg_exp = {BUS_REQ.wdata[1], &BUS_REQ.wdata[1:0], BUS_REQ.wdata[2]};
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  a_rd_answer: assert property (rd_go |=> BUS_RSP.valid)
    else $error("Read not answered");
  a_rsp_hold: assert property (!rd_go |=> $stable(BUS_RSP.data))
    else $error("Read data moved");
  a_dc_write: assert property (wr_go && BUS_REQ.addr == 8'h07
    |=> DC_LEVEL == $past(BUS_REQ.wdata)) else $error("Level not written");
  a_dc_read: assert property (rd_go && !wr_go && BUS_REQ.addr == 8'h07
    |=> BUS_RSP.data == DC_LEVEL) else $error("Level read wrong");
  a_cfg_decode: assert property (wr_go && BUS_REQ.addr == 8'h08
    |-> ##2 ANALOG_CFG == $past(cfg_exp, 2)) else $error("Bad decode");
  a_cfg_read: assert property (rd_go && BUS_REQ.addr == 8'h08
    |=> BUS_RSP.data[7:3] == 5'h00) else $error("Config spare set");
  a_ch_read: assert property (rd_go && BUS_REQ.addr == 8'h09
    |=> BUS_RSP.data[7:6] == 2'h0) else $error("Channel spare set");
  a_unmapped_zero: assert property (rd_go && !mapped
    |=> BUS_RSP.data == 8'h00) else $error("Unmapped read nonzero");
  c_pwm_write: cover property (wr_go && BUS_REQ.addr == 8'h00);
  c_cfg_write: cover property (wr_go && BUS_REQ.addr == 8'h08);
  c_full_on: cover property (LED_PWM == 6'h3f);
endmodule : ldr_bank_props

/* File: ldr_host.sv */
module ldr_host (
  // Clock and register port
  input wire logic clk,
  input wire ldr_pkg::ldr_rsp_t rsp,
  output ldr_pkg::ldr_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  // Idle lines show inverted values, never a stale copy
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '{1'b0, 1'b0, ~a, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '{1'b0, 1'b0, ~a, 8'hff};
    #1;
    d = rsp.valid ? rsp.data : 8'hxx;
  endtask : rd
endmodule : ldr_host

/* File: ldr_bank_tb.sv */
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  mismatches++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); \
  end end
module ldr_bank_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic src = 1'b0;
  logic [5:0] fault = 6'h00;
  logic ce = 1'b1;
  logic interp = 1'b1;
  logic ext_pwm = 1'b0;
  logic [1:0] ph = 2'h0;
  logic [7:0] d;
  logic [15:0] c;
  int mismatches = 0;
  int samples_checked = 0;
  ldr_pkg::ldr_req_t req;
  ldr_pkg::ldr_rsp_t rsp;
  logic [5:0] led;
  logic [7:0] dc;
  ldr_pkg::ldr_analog_t acfg;
  always #5 clk = ~clk;
  // External dimming input: high two clocks of every three
  always @(posedge clk) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    ext_pwm <= (ph != 2'h0);
  end
  ldr_host i_host (.clk(clk), .rsp(rsp), .req(req));
  ldr_bank i_dut (.CLK(clk), .RESET(reset), .CE(ce), .BUS_REQ(req),
    .BUS_RSP(rsp), .DIM_SRC_SEL(src), .DIM_INTERP_SEL(interp),
    .EXT_PWM_INPUT(ext_pwm), .CH_FAULT(fault), .LED_PWM(led), .DC_LEVEL(dc),
    .ANALOG_CFG(acfg));
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_host.rd(a, d);
    `CHK(d, e)
  endtask : rd_chk
  // Two whole periods, so the count does not depend on phase
  task automatic duty(input logic [15:0] e);
    c = 16'h0000;
    repeat (300) @(posedge clk);
    repeat (510) begin
      @(posedge clk);
      #1;
      c = c + led[0];
    end
    `CHK(c, e)
  endtask : duty
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd_chk(8'h00, 8'hff);
    rd_chk(8'h07, 8'hff);
    rd_chk(8'h08, 8'h07);
    rd_chk(8'h09, 8'h3f);
    rd_chk(8'h05, 8'h00);
    $display("reset test done");
    @(posedge clk);
    src <= 1'b1;
    i_host.wr(8'h00, 8'h40);
    rd_chk(8'h00, 8'hff);
    @(posedge clk);
    src <= 1'b0;
    duty(16'd510);
    i_host.wr(8'h00, 8'h00);
    duty(16'd0);
    i_host.wr(8'h00, 8'h80);
    rd_chk(8'h00, 8'h80);
    duty(16'd256);
    $display("dimming test done");
    for (int i = 0; i < 8; i++) begin
      i_host.wr(8'h08, 8'(i));
      repeat (2) @(posedge clk);
      #1;
      `CHK(acfg, {i[1], i[1] & i[0], i[2]})
      rd_chk(8'h08, 8'(i));
    end
    i_host.wr(8'h07, 8'h5a);
    rd_chk(8'h07, 8'h5a);
    `CHK(dc, 8'h5a)
    i_host.wr(8'h00, 8'hff);
    @(posedge clk);
    fault <= 6'h01;
    i_host.wr(8'h09, 8'h15);
    repeat (3) @(posedge clk);
    #1;
    `CHK(led, 6'h15)
    rd_chk(8'h09, 8'h14);
    $display("register test done");
    @(posedge clk);
    ce <= 1'b0;
    i_host.wr(8'h07, 8'h33);
    ce <= 1'b1;
    rd_chk(8'h07, 8'h5a);
    @(posedge clk);
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd_chk(8'h00, 8'hff);
    rd_chk(8'h07, 8'hff);
    $display("enable and reset test done");
    // A full measuring window of the external input must pass first
    repeat (66000) @(posedge clk);
    src <= 1'b1;
    duty(16'd340);
    @(posedge clk);
    src <= 1'b0;
    interp <= 1'b0;
    i_host.wr(8'h00, 8'h80);
    duty(16'd170);
    $display("source test done");
    conclude();
  end
  initial begin
    // Covers the long measuring wait plus the register tests
    repeat (80000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule : ldr_bank_tb
bind ldr_bank ldr_bank_props i_props (.CLK(CLK), .RESET(RESET), .CE(CE),
  .BUS_REQ(BUS_REQ), .BUS_RSP(BUS_RSP), .LED_PWM(LED_PWM),
  .DC_LEVEL(DC_LEVEL), .ANALOG_CFG(ANALOG_CFG));
